// *** hdl/qhp_bus_if.sv ***
`timescale 1ns/10ps
interface qhp_bus_if;
  logic bus_style;
  logic read_strobe_n;
  logic write_strobe_n;
  logic chan_a_select_n;
  logic chan_b_select_n;
  logic chan_c_select_n;
  logic chan_d_select_n;
  logic [2:0] reg_addr;
  logic [7:0] host_data_out;
  logic host_data_oe;
  logic [7:0] dev_data_out;
  logic dev_data_oe;
  logic [7:0] data_bus;

  // wire level of the shared data bus; idle bus floats high
  assign data_bus = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : qhp_pkg::QHP_BUS_IDLE);

  modport dev (
    input bus_style, read_strobe_n, write_strobe_n,
    input chan_a_select_n, chan_b_select_n, chan_c_select_n, chan_d_select_n,
    input reg_addr, data_bus,
    output dev_data_out, dev_data_oe
  );

  modport host (
    output bus_style, read_strobe_n, write_strobe_n,
    output chan_a_select_n, chan_b_select_n, chan_c_select_n, chan_d_select_n,
    output reg_addr, host_data_out, host_data_oe,
    input data_bus
  );
endinterface

// *** hdl/qhp_dev_port.sv ***
`timescale 1ns/10ps
// Operation
// [R01] three address bits pick channel register
// [R02] eight-bit data bus, device drives only reads
// [R03] style pin high selects separate strobes
// [R04] read strobe fall reads, host samples rise
// [R05] write strobe rise stores bus byte
// [R06] style low ignores read strobe
// [R07] style low: write strobe is direction
// [R08] strobe mode channels A-C need own select
// [R09] level mode: select A is device select
// [R10] level mode: selects B,C are channel bits
// [R11] select D only in strobe mode
// [R12] channel bits 0..3 pick A..D
// [R13] host: one select, never both strobes
module qhp_dev_port
  import qhp_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  qhp_bus_if.dev bus,
  output logic req_valid,
  output logic req_write,
  output logic [1:0] req_chan,
  output logic [2:0] req_addr,
  output logic [7:0] req_wdata,
  input wire logic [7:0] rd_data,
  output logic style_strobe
);

  localparam int unsigned PIN_W = 18;
  // the chain starts from the idle pin levels, so no false edge follows reset
  localparam logic [PIN_W-1:0] PIN_RST = {QHP_STYLE_STROBE, 1'b1, 1'b1, 4'hF,
                                          QHP_ADDR_RST, QHP_BUS_IDLE};

  // every pin is asynchronous to clock; two stages before any use
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] sync1_q;
  logic [PIN_W-1:0] sync2_q;

  assign pins_raw = {bus.bus_style,
                     bus.read_strobe_n,
                     bus.write_strobe_n,
                     bus.chan_d_select_n,
                     bus.chan_c_select_n,
                     bus.chan_b_select_n,
                     bus.chan_a_select_n,
                     bus.reg_addr,
                     bus.data_bus};

  always_ff @(posedge clock) begin
    if (!nrst) begin
      sync1_q <= PIN_RST;
      sync2_q <= PIN_RST;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  wire s_style = sync2_q[17];
  wire s_rd_n = sync2_q[16];
  wire s_wr_n = sync2_q[15];
  wire [3:0] s_sel_n = sync2_q[14:11];
  wire [2:0] s_addr = sync2_q[10:8];
  wire [7:0] s_data = sync2_q[7:0];

  // the style pin passes the same two stages as the strobes, so a mode change
  // and the first access of the new mode are seen in the order the host drove them
  wire strobe_mode = (s_style == QHP_STYLE_STROBE); // [R03]

  // strobe mode: any one of the four selects enables its channel
  // several selects low is a host fault; the priority function picks A first
  wire any_sel = ~&s_sel_n; // [R08] [R11]
  wire strb_rd = strobe_mode & ~s_rd_n & any_sel; // [R04]
  wire strb_wr = strobe_mode & ~s_wr_n & any_sel; // [R05]
  wire [1:0] strb_chan = qhp_sel_to_chan(s_sel_n); // [R08] [R11]

  // level mode: read strobe and select D are not looked at
  // select A low acts as the strobe of a level-mode access
  wire lvl_sel = ~strobe_mode & ~s_sel_n[0]; // [R09] [R06] [R11]
  wire lvl_rd = lvl_sel & s_wr_n; // [R07]
  wire lvl_wr = lvl_sel & ~s_wr_n; // [R07]
  wire [1:0] lvl_chan = {s_sel_n[2], s_sel_n[1]}; // [R10] [R12]

  wire rd_act = strb_rd | lvl_rd;
  wire wr_act = strb_wr | lvl_wr;
  wire [1:0] cur_chan = strobe_mode ? strb_chan : lvl_chan;

  logic rd_act_q;
  logic wr_act_q;
  logic rd_pend_q;
  logic [1:0] wr_chan_q;
  logic [2:0] wr_addr_q;
  logic [7:0] wr_data_q;

  // a read is started by the leading edge; a write lands on the trailing edge
  wire rd_start = rd_act & ~rd_act_q; // [R04]
  wire wr_end = ~wr_act & wr_act_q; // [R05]

  always_ff @(posedge clock) begin
    if (!nrst) begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
    end else begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
    end
  end

  // the last byte seen while the write was active is the one stored,
  // since the bus may already be released when the edge is synchronised
  always_ff @(posedge clock) begin
    if (!nrst) begin
      wr_chan_q <= QHP_CHAN_A;
      wr_addr_q <= QHP_ADDR_RST;
      wr_data_q <= QHP_DATA_RST;
    end else if (wr_act) begin
      wr_chan_q <= cur_chan;
      wr_addr_q <= s_addr; // [R01]
      wr_data_q <= s_data; // [R05]
    end
  end

  logic req_valid_q;
  logic req_write_q;
  logic [1:0] req_chan_q;
  logic [2:0] req_addr_q;
  logic [7:0] req_wdata_q;

  // a write commit outranks a read start that lands in the same cycle
  wire req_load = rd_start | wr_end;
  wire req_write_d = wr_end;
  wire [1:0] req_chan_d = wr_end ? wr_chan_q : cur_chan; // [R12]
  wire [2:0] req_addr_d = wr_end ? wr_addr_q : s_addr; // [R01]
  wire [7:0] req_wdata_d = wr_end ? wr_data_q : req_wdata_q; // [R05]

  always_ff @(posedge clock) begin
    if (!nrst) begin
      req_valid_q <= 1'b0;
    end else begin
      req_valid_q <= req_load;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      req_write_q <= 1'b0;
      req_chan_q <= QHP_CHAN_A;
      req_addr_q <= QHP_ADDR_RST;
      req_wdata_q <= QHP_DATA_RST;
    end else if (req_load) begin
      req_write_q <= req_write_d;
      req_chan_q <= req_chan_d;
      req_addr_q <= req_addr_d;
      req_wdata_q <= req_wdata_d;
    end
  end

  // user logic answers a read combinationally in the cycle of req_valid
  logic [7:0] dev_data_q;
  logic dev_oe_q;

  // drive only while the read is held active, never during a write
  wire dev_oe_d = rd_act & ~wr_act; // [R02]

  always_ff @(posedge clock) begin
    if (!nrst) begin
      rd_pend_q <= 1'b0;
      dev_data_q <= QHP_DATA_RST;
    end else begin
      rd_pend_q <= rd_start;
      if (rd_pend_q) begin
        dev_data_q <= rd_data; // [R04]
      end
    end
  end

  // the bus is let go three cycles after the strobe rises; a host must not
  // drive it again before then
  always_ff @(posedge clock) begin
    if (!nrst) begin
      dev_oe_q <= 1'b0;
    end else begin
      dev_oe_q <= dev_oe_d;
    end
  end

  // tells user logic which bus style the host is using
  logic style_q;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      style_q <= QHP_STYLE_STROBE;
    end else begin
      style_q <= strobe_mode;
    end
  end

  assign bus.dev_data_out = dev_data_q;
  assign bus.dev_data_oe = dev_oe_q;
  assign req_valid = req_valid_q;
  assign req_write = req_write_q;
  assign req_chan = req_chan_q;
  assign req_addr = req_addr_q;
  assign req_wdata = req_wdata_q;
  assign style_strobe = style_q;

endmodule // qhp_dev_port

// *** hdl/qhp_host_port.sv ***
`timescale 1ns/10ps
module qhp_host_port
  import qhp_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  qhp_bus_if.host bus,
  input wire logic style_sel,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [1:0] cmd_chan,
  input wire logic [2:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ready,
  output logic rd_valid,
  output logic [7:0] rd_data
);

  // returned data is asynchronous to clock; two stages before sampling
  logic [7:0] din1_q;
  logic [7:0] din2_q;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      din1_q <= QHP_BUS_IDLE;
      din2_q <= QHP_BUS_IDLE;
    end else begin
      din1_q <= bus.data_bus;
      din2_q <= din1_q;
    end
  end

  qhp_host_state_t state_q, state_d;
  logic ready_q;
  logic [QHP_CNT_W-1:0] cnt_q;
  logic style_q;
  logic write_q;
  logic [1:0] chan_q;
  logic [2:0] addr_q;
  logic [7:0] wdata_q;

  wire cnt_done = (cnt_q == '0);
  wire take = (state_q == QHP_IDLE) & cmd_valid;
  // strobe width covers the far end's synchroniser and answer latency
  wire sample = (state_q == QHP_STROBE) & cnt_done; // [R04]

  always_comb begin
    state_d = state_q;
    case (state_q)
      QHP_IDLE: if (cmd_valid) state_d = QHP_SETUP;
      QHP_SETUP: if (cnt_done) state_d = QHP_STROBE;
      QHP_STROBE: if (cnt_done) state_d = QHP_HOLD;
      QHP_HOLD: if (cnt_done) state_d = QHP_IDLE;
      default: state_d = QHP_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_q <= QHP_IDLE;
      ready_q <= 1'b1;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      ready_q <= (state_d == QHP_IDLE);
      if (take) begin
        cnt_q <= QHP_CNT_W'(QHP_SETUP_CYC - 1);
      end else if (state_q == QHP_SETUP && cnt_done) begin
        cnt_q <= QHP_CNT_W'(QHP_STROBE_CYC - 1);
      end else if (state_q == QHP_STROBE && cnt_done) begin
        cnt_q <= QHP_CNT_W'(QHP_HOLD_CYC - 1);
      end else if (!cnt_done) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      style_q <= QHP_STYLE_STROBE;
      write_q <= 1'b0;
      chan_q <= QHP_CHAN_A;
      addr_q <= QHP_ADDR_RST;
      wdata_q <= QHP_DATA_RST;
    end else if (take) begin
      style_q <= style_sel;
      write_q <= cmd_write;
      chan_q <= cmd_chan;
      addr_q <= cmd_addr;
      wdata_q <= cmd_wdata;
    end
  end

  // pin values of the next cycle
  wire nxt_busy = (state_d != QHP_IDLE);
  wire nxt_strobe = (state_d == QHP_STROBE);
  wire nxt_style = take ? style_sel : style_q;
  wire nxt_write = take ? cmd_write : write_q;
  wire [1:0] nxt_chan = take ? cmd_chan : chan_q;
  wire [2:0] nxt_addr = take ? cmd_addr : addr_q;
  wire [7:0] nxt_wdata = take ? cmd_wdata : wdata_q;
  wire [3:0] one_sel_n = nxt_busy ? qhp_chan_to_sel(nxt_chan) : 4'hF; // [R13]
  wire lvl = (nxt_style == QHP_STYLE_LEVEL);

  logic style_pin_q;
  logic rd_n_q;
  logic wr_n_q;
  logic [3:0] sel_n_q;
  logic [2:0] addr_pin_q;
  logic [7:0] dout_q;
  logic oe_q;
  logic rd_valid_q;
  logic [7:0] rd_data_q;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      style_pin_q <= QHP_STYLE_STROBE;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      sel_n_q <= 4'hF;
      addr_pin_q <= QHP_ADDR_RST;
      dout_q <= QHP_DATA_RST;
      oe_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= QHP_DATA_RST;
    end else begin
      style_pin_q <= nxt_style;
      addr_pin_q <= nxt_addr; // [R01]
      dout_q <= nxt_wdata;
      oe_q <= nxt_busy & nxt_write; // [R02]
      if (lvl) begin
        rd_n_q <= 1'b1; // [R06]
        wr_n_q <= ~nxt_write; // [R07]
        sel_n_q <= {1'b1, nxt_chan[1], nxt_chan[0], ~nxt_strobe}; // [R09] [R10] [R11] [R12]
      end else begin
        rd_n_q <= ~(nxt_strobe & ~nxt_write); // [R04] [R13]
        wr_n_q <= ~(nxt_strobe & nxt_write); // [R05] [R13]
        sel_n_q <= one_sel_n; // [R08] [R11]
      end
      rd_valid_q <= sample & ~write_q;
      if (sample & ~write_q) begin
        rd_data_q <= din2_q; // [R04]
      end
    end
  end

  assign bus.bus_style = style_pin_q;
  assign bus.read_strobe_n = rd_n_q;
  assign bus.write_strobe_n = wr_n_q;
  assign bus.chan_a_select_n = sel_n_q[0];
  assign bus.chan_b_select_n = sel_n_q[1];
  assign bus.chan_c_select_n = sel_n_q[2];
  assign bus.chan_d_select_n = sel_n_q[3];
  assign bus.reg_addr = addr_pin_q;
  assign bus.host_data_out = dout_q;
  assign bus.host_data_oe = oe_q;
  assign cmd_ready = ready_q;
  assign rd_valid = rd_valid_q;
  assign rd_data = rd_data_q;

endmodule // qhp_host_port

// *** hdl/qhp_pkg.sv ***
package qhp_pkg;

  localparam int unsigned QHP_CLK_PERIOD_NS = 5;

  // host-side pin timing, in ns as specified and as derived cycle counts
  localparam int unsigned QHP_SETUP_NS = 10;
  localparam int unsigned QHP_STROBE_NS = 40;
  localparam int unsigned QHP_HOLD_NS = 10;

  // least times round up to whole cycles
  localparam int unsigned QHP_SETUP_CYC = (QHP_SETUP_NS + QHP_CLK_PERIOD_NS - 1) / QHP_CLK_PERIOD_NS;
  localparam int unsigned QHP_STROBE_CYC = (QHP_STROBE_NS + QHP_CLK_PERIOD_NS - 1) / QHP_CLK_PERIOD_NS;
  localparam int unsigned QHP_HOLD_CYC = (QHP_HOLD_NS + QHP_CLK_PERIOD_NS - 1) / QHP_CLK_PERIOD_NS;

  localparam int unsigned QHP_CNT_W = 4;

  // value on the data bus when nobody drives it (pull-ups)
  localparam logic [7:0] QHP_BUS_IDLE = 8'hFF;
  localparam logic [7:0] QHP_DATA_RST = 8'h00;
  localparam logic [2:0] QHP_ADDR_RST = 3'h0;

  // bus style pin levels
  localparam logic QHP_STYLE_STROBE = 1'b1;
  localparam logic QHP_STYLE_LEVEL = 1'b0;

  // channel codes
  localparam logic [1:0] QHP_CHAN_A = 2'h0;
  localparam logic [1:0] QHP_CHAN_B = 2'h1;
  localparam logic [1:0] QHP_CHAN_C = 2'h2;
  localparam logic [1:0] QHP_CHAN_D = 2'h3;

  typedef enum logic [1:0] {
    QHP_IDLE = 2'b00,
    QHP_SETUP = 2'b01,
    QHP_STROBE = 2'b10,
    QHP_HOLD = 2'b11
  } qhp_host_state_t;

  // active-low one-hot chip selects to channel code, A wins if several are low
  function automatic logic [1:0] qhp_sel_to_chan(input logic [3:0] sel_n);
    logic [1:0] chan;
    chan = QHP_CHAN_D;
    if (!sel_n[0]) begin
      chan = QHP_CHAN_A;
    end else if (!sel_n[1]) begin
      chan = QHP_CHAN_B;
    end else if (!sel_n[2]) begin
      chan = QHP_CHAN_C;
    end
    return chan;
  endfunction

  // channel code to active-low one-hot chip selects
  function automatic logic [3:0] qhp_chan_to_sel(input logic [1:0] chan);
    logic [3:0] sel_n;
    sel_n = 4'hF;
    sel_n[chan] = 1'b0;
    return sel_n;
  endfunction

endpackage

// *** testbench/qhp_bus_asserts.sv ***
`timescale 1ns/10ps
module qhp_bus_asserts (
  input wire logic clock,
  input wire logic nrst,
  input wire logic bus_style,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  input wire logic chan_c_select_n,
  input wire logic chan_d_select_n,
  input wire logic host_data_oe,
  input wire logic dev_data_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic [3:0] sel_n;
  assign sel_n = {chan_d_select_n, chan_c_select_n, chan_b_select_n, chan_a_select_n};

  chk_bus_no_fight: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive the data bus");
  chk_strobes_apart: assert property (bus_style |-> (read_strobe_n || write_strobe_n))
    else $error("read and write strobes low together");
  chk_one_select: assert property (bus_style |-> $countones(~sel_n) <= 1)
    else $error("several channel selects low");
  chk_level_d_idle: assert property (!bus_style |-> chan_d_select_n)
    else $error("select d used in level mode");
  chk_level_no_rd: assert property (!bus_style |-> read_strobe_n)
    else $error("read strobe used in level mode");
  chk_read_has_sel: assert property (bus_style && $fell(read_strobe_n) |-> sel_n != 4'hF)
    else $error("read strobe without a select");
  chk_read_drives: assert property (bus_style && $fell(read_strobe_n) |-> ##[2:5] dev_data_oe)
    else $error("device did not drive read data");
  chk_read_release: assert property (bus_style && $rose(read_strobe_n) |-> ##[1:5] !dev_data_oe)
    else $error("device kept driving after read");
  chk_level_read: assert property (!bus_style && write_strobe_n && $fell(chan_a_select_n)
    |-> ##[2:5] dev_data_oe)
    else $error("level mode read not answered");
  chk_write_holds: assert property ($past(bus_style) && bus_style && $rose(write_strobe_n)
    |-> host_data_oe)
    else $error("write data gone at strobe rise");
endmodule // qhp_bus_asserts

// *** testbench/quad_channel_host_bus_port_bench.sv ***
`timescale 1ns/10ps
module quad_channel_host_bus_port_bench;
  import qhp_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic style_sel = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [1:0] cmd_chan = 2'h0;
  logic [2:0] cmd_addr = 3'h0;
  logic [7:0] cmd_wdata = 8'h00;
  logic [7:0] salt = 8'h00;
  logic [31:0] r = 32'h0;
  logic cmd_ready, rd_valid, req_valid, req_write, style_strobe;
  logic [7:0] host_rd_data, dev_rd_data, req_wdata;
  logic [1:0] req_chan;
  logic [2:0] req_addr;
  logic [3:0] sel_n;
  int failures = 0;
  int check_count = 0;
  integer seed = 32'h29557f91;

  qhp_bus_if bus_if ();
  always #2.5 clock = ~clock;

  // answer byte depends on channel and address so a misrouted access shows
  function automatic logic [7:0] rd_pat(input logic [1:0] c, input logic [2:0] a, input logic [7:0] s);
    return {c, a, ~a} ^ s;
  endfunction
  assign dev_rd_data = rd_pat(req_chan, req_addr, salt);
  assign sel_n = {bus_if.chan_d_select_n, bus_if.chan_c_select_n, bus_if.chan_b_select_n, bus_if.chan_a_select_n};

  qhp_host_port qhp_host_port_inst (.clock(clock), .nrst(nrst), .bus(bus_if.host), .style_sel(style_sel),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_chan(cmd_chan), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rd_valid(rd_valid), .rd_data(host_rd_data));
  qhp_dev_port qhp_dev_port_inst (.clock(clock), .nrst(nrst), .bus(bus_if.dev), .req_valid(req_valid),
    .req_write(req_write), .req_chan(req_chan), .req_addr(req_addr), .req_wdata(req_wdata),
    .rd_data(dev_rd_data), .style_strobe(style_strobe));
  qhp_bus_asserts qhp_bus_asserts_inst (.clock(clock), .nrst(nrst), .bus_style(bus_if.bus_style),
    .read_strobe_n(bus_if.read_strobe_n), .write_strobe_n(bus_if.write_strobe_n),
    .chan_a_select_n(bus_if.chan_a_select_n), .chan_b_select_n(bus_if.chan_b_select_n),
    .chan_c_select_n(bus_if.chan_c_select_n), .chan_d_select_n(bus_if.chan_d_select_n),
    .host_data_oe(bus_if.host_data_oe), .dev_data_oe(bus_if.dev_data_oe));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (failures == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic run(input logic sty, input logic wr, input logic [1:0] ch, input logic [2:0] ad,
                     input logic [7:0] wd);
    logic got_req;
    logic got_rd;
    int n;
    got_req = 1'b0;
    got_rd = 1'b0;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk({7'h0, cmd_ready}, 8'h01, "host ready");
    @(posedge clock);
    style_sel <= sty;
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_chan <= ch;
    cmd_addr <= ad;
    cmd_wdata <= wd;
    salt <= r[23:16];
    @(posedge clock);
    cmd_valid <= 1'b0;
    for (int i = 1; i <= 40; i++) begin
      @(posedge clock);
      #1;
      if (i == 5) begin
        chk({4'h0, sel_n}, {4'h0, sty ? ~(4'h1 << ch) : {1'b1, ch, 1'b0}}, "selects");
        chk({6'h0, bus_if.read_strobe_n, bus_if.write_strobe_n}, {6'h0, ~sty | wr, ~wr}, "strobes");
        chk({5'h0, bus_if.reg_addr}, {5'h0, ad}, "address pins");
        if (wr) begin
          chk(bus_if.data_bus, wd, "write data on bus");
        end
      end
      if (i == 8 && !wr) begin
        chk(bus_if.data_bus, rd_pat(ch, ad, salt), "read data on bus");
      end
      if (req_valid === 1'b1) begin
        got_req = 1'b1;
        chk({2'h0, req_write, req_chan, req_addr}, {2'h0, wr, ch, ad}, "device request");
        if (wr) begin
          chk(req_wdata, wd, "stored byte");
        end
      end
      if (rd_valid === 1'b1) begin
        got_rd = 1'b1;
        chk(host_rd_data, rd_pat(ch, ad, salt), "read byte");
      end
      if (cmd_ready === 1'b1 && got_req && (wr || got_rd)) begin
        break;
      end
    end
    chk({6'h0, got_req, got_rd | wr}, 8'h03, "missing answer");
    chk({7'h0, style_strobe}, {7'h0, sty}, "bus style");
  endtask

  initial begin
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    for (int k = 0; k < 40; k++) begin
      r = $random(seed);
      if (k < 16) begin
        run(k[0], k[1], k[3:2], k[1] ? 3'h7 : 3'h0, k[0] ? 8'hA5 : 8'h5A);
      end else begin
        run(r[0], r[1], r[3:2], r[6:4], r[15:8]);
      end
    end
    wrap_up();
  end

  // forty transfers of under twenty cycles each fit well inside this span
  initial begin
    repeat (5000) @(posedge clock);
    failures++;
    wrap_up();
  end
endmodule // quad_channel_host_bus_port_bench
